// File: hdl/tmrc_pkg.sv
// Behaviour
// - Go bit sets channel running bit
// - Halt bit clears running bit, stops count
// - Go initialises counter then starts counting
// - Go bits self-clear once channel enabled
// - Halt bits self-clear once channel stopped
// - Go trigger registers always read zero
// - Halt trigger registers always read zero
// - Reset clears status and trigger registers
// - Low status: bits 0,1 show channels
// - Split mode: upper status bit 1 shows upper
// - Split: low go bit starts lower only
// - Split: upper go starts upper, interval mode
// - Split: low/upper halt bits stop respective halves
// - Bit or byte trigger writes; byte reads
// - One-count restart: reinit, no interrupt
package tmrc_pkg;
  localparam int          ADDR_W            = 20;
  localparam int          DATA_W            = 8;
  localparam int          UNITS             = 3;
  localparam logic [19:0] ADDR_RUN_STATE    = 20'hf01b0;
  localparam logic [19:0] ADDR_RUN_STATE_UP = 20'hf01b1;
  localparam logic [19:0] ADDR_GO_TRIG      = 20'hf01b2;
  localparam logic [19:0] ADDR_GO_TRIG_UP   = 20'hf01b3;
  localparam logic [19:0] ADDR_HALT_TRIG    = 20'hf01b4;
  localparam logic [19:0] ADDR_HALT_TRIG_UP = 20'hf01b5;
  localparam logic [7:0]  REG_RESET         = 8'h00;
  localparam int          BIT_CH0           = 0;
  localparam int          BIT_CH1           = 1;
  localparam int          UNIT_CH0          = 0;
  localparam int          UNIT_CH1_LOW      = 1;
  localparam int          UNIT_CH1_UP       = 2;
  // Mode field: three mode bits of the channel mode register
  localparam logic [2:0]  MODE_INTERVAL     = 3'h0;
  localparam logic [2:0]  MODE_CAPTURE      = 3'h2;
  localparam logic [2:0]  MODE_EVENT        = 3'h3;
  localparam logic [2:0]  MODE_ONE_COUNT    = 3'h4;
  localparam logic [2:0]  MODE_CAP_ONE      = 3'h6;
  // Software wait before go when timer input pin is used
  localparam int          WAIT_FILTER_ON    = 4;
  localparam int          WAIT_FILTER_OFF   = 2;
endpackage

// File: hdl/tmrc_unit_if.sv
`timescale 1ns/1ps
interface tmrc_unit_if;
  logic go_set;
  logic halt_set;
  logic restart_ok;
  logic run;
  logic init;
  logic restart;
  logic go_pend;
  logic halt_pend;
  modport unit (
    input  go_set,
    input  halt_set,
    input  restart_ok,
    output run,
    output init,
    output restart,
    output go_pend,
    output halt_pend
  );
  modport ctrl (
    output go_set,
    output halt_set,
    output restart_ok,
    input  run,
    input  init,
    input  restart,
    input  go_pend,
    input  halt_pend
  );
endinterface

// File: hdl/tmrc_run_unit.sv
`timescale 1ns/1ps
module tmrc_run_unit (
  input wire logic clk_sys,
  input wire logic srst,
  tmrc_unit_if.unit u
);
  logic go_reg;
  logic go_next;
  logic halt_reg;
  logic halt_next;
  logic run_reg;
  logic run_next;
  logic init_reg;
  logic init_next;
  logic rst_reg;
  logic rst_next;

  always_comb begin
    go_next   = u.go_set;
    halt_next = u.halt_set;
    run_next  = run_reg;
    init_next = 1'b0;
    rst_next  = 1'b0;
    if (halt_reg) begin
      run_next = 1'b0;
    end else if (go_reg) begin
      if (!run_reg) begin
        run_next  = 1'b1;
        init_next = 1'b1;
      end else if (u.restart_ok) begin
        init_next = 1'b1;
        rst_next  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      go_reg   <= 1'b0;
      halt_reg <= 1'b0;
      run_reg  <= 1'b0;
      init_reg <= 1'b0;
      rst_reg  <= 1'b0;
    end else begin
      go_reg   <= go_next;
      halt_reg <= halt_next;
      run_reg  <= run_next;
      init_reg <= init_next;
      rst_reg  <= rst_next;
    end
  end

  assign u.run       = run_reg;
  assign u.init      = init_reg;
  assign u.restart   = rst_reg;
  assign u.go_pend   = go_reg;
  assign u.halt_pend = halt_reg;

  go_sets_run_a: assert property (@(posedge clk_sys) disable iff (srst)
    u.go_set && !u.halt_set ##1 !srst ##0 !halt_reg |=> run_reg)
    else $error("go did not set running bit");
  halt_clears_a: assert property (@(posedge clk_sys) disable iff (srst)
    u.halt_set |=> ##1 !run_reg)
    else $error("halt did not clear running bit");
  init_on_start_a: assert property (@(posedge clk_sys) disable iff (srst)
    !run_reg && $rose(run_reg) == 1'b0 ##1 $rose(run_reg) |-> init_reg)
    else $error("start without counter init");
  go_clears_a: assert property (@(posedge clk_sys) disable iff (srst)
    go_reg && !u.go_set |=> !go_reg)
    else $error("go bit did not self-clear");
  halt_clears_bit_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    halt_reg && !u.halt_set |=> !halt_reg && !run_reg)
    else $error("halt bit did not self-clear");
  reset_clears_a: assert property (@(posedge clk_sys)
    srst |=> !run_reg && !go_reg && !halt_reg && !init_reg)
    else $error("reset left state set");
  restart_init_a: assert property (@(posedge clk_sys) disable iff (srst)
    go_reg && run_reg && !halt_reg && u.restart_ok |=> init_reg && rst_reg)
    else $error("restart did not reinitialise");
  blocked_go_a: assert property (@(posedge clk_sys) disable iff (srst)
    go_reg && run_reg && !u.restart_ok |=> !init_reg && run_reg)
    else $error("blocked go changed state");
endmodule // tmrc_run_unit

// File: hdl/tmrc_run_ctrl.sv
`timescale 1ns/1ps
module tmrc_run_ctrl (
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic [tmrc_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic                        bus_wr,
  input  wire logic                        bus_rd,
  input  wire logic [tmrc_pkg::DATA_W-1:0] bus_wdata,
  input  wire logic [tmrc_pkg::DATA_W-1:0] bus_wmask,
  input  wire logic [2:0]                  ch0_mode,
  input  wire logic [2:0]                  ch1_mode,
  input  wire logic [1:0]                  start_option_bit,
  input  wire logic                        split_mode,
  output logic      [tmrc_pkg::DATA_W-1:0] bus_rdata,
  output logic      [tmrc_pkg::UNITS-1:0]  run_enable,
  output logic      [tmrc_pkg::UNITS-1:0]  count_init,
  output logic      [tmrc_pkg::UNITS-1:0]  count_restart
);
  localparam int N = tmrc_pkg::UNITS;

  tmrc_unit_if unit_bus [N] ();

  logic [tmrc_pkg::DATA_W-1:0] wbits;
  logic [N-1:0]                go_set;
  logic [N-1:0]                halt_set;
  logic [N-1:0]                restart_ok;
  logic [N-1:0]                run_w;
  logic [N-1:0]                init_w;
  logic [N-1:0]                rst_w;
  logic [tmrc_pkg::DATA_W-1:0] rdata_reg;
  logic [tmrc_pkg::DATA_W-1:0] rdata_next;
  logic [N-1:0]                run_reg;
  logic [N-1:0]                init_reg;
  logic [N-1:0]                rst_reg;

  // Only bits both written as 1 and selected by the mask act
  assign wbits = bus_wdata & bus_wmask;

  function automatic logic restart_allowed(input logic [2:0] mode,
                                           input logic       opt);
    logic ok;
    ok = 1'b1;
    if (mode == tmrc_pkg::MODE_CAP_ONE) begin
      ok = 1'b0;
    end else if (mode == tmrc_pkg::MODE_ONE_COUNT) begin
      ok = opt;
    end
    return ok;
  endfunction

  always_comb begin
    go_set     = '0;
    halt_set   = '0;
    restart_ok = '0;
    if (bus_wr) begin
      case (bus_addr)
        tmrc_pkg::ADDR_GO_TRIG: begin
          go_set[tmrc_pkg::UNIT_CH0]     = wbits[tmrc_pkg::BIT_CH0];
          go_set[tmrc_pkg::UNIT_CH1_LOW] = wbits[tmrc_pkg::BIT_CH1];
        end
        tmrc_pkg::ADDR_GO_TRIG_UP: begin
          go_set[tmrc_pkg::UNIT_CH1_UP] = split_mode &
                                          wbits[tmrc_pkg::BIT_CH1];
        end
        tmrc_pkg::ADDR_HALT_TRIG: begin
          halt_set[tmrc_pkg::UNIT_CH0]     = wbits[tmrc_pkg::BIT_CH0];
          halt_set[tmrc_pkg::UNIT_CH1_LOW] = wbits[tmrc_pkg::BIT_CH1];
        end
        tmrc_pkg::ADDR_HALT_TRIG_UP: begin
          halt_set[tmrc_pkg::UNIT_CH1_UP] = wbits[tmrc_pkg::BIT_CH1];
        end
        default: begin
          go_set = '0;
        end
      endcase
    end
    restart_ok[tmrc_pkg::UNIT_CH0] =
      restart_allowed(ch0_mode, start_option_bit[tmrc_pkg::BIT_CH0]);
    restart_ok[tmrc_pkg::UNIT_CH1_LOW] =
      restart_allowed(ch1_mode, start_option_bit[tmrc_pkg::BIT_CH1]);
    // Upper half always counts as an interval timer
    restart_ok[tmrc_pkg::UNIT_CH1_UP] =
      restart_allowed(tmrc_pkg::MODE_INTERVAL, 1'b0);
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_unit
      assign unit_bus[g].go_set     = go_set[g];
      assign unit_bus[g].halt_set   = halt_set[g];
      assign unit_bus[g].restart_ok = restart_ok[g];
      assign run_w[g]               = unit_bus[g].run;
      assign init_w[g]              = unit_bus[g].init;
      assign rst_w[g]               = unit_bus[g].restart;
      tmrc_run_unit u_unit (
        .clk_sys (clk_sys),
        .srst    (srst),
        .u       (unit_bus[g])
      );
    end
  endgenerate

  always_comb begin
    rdata_next = tmrc_pkg::REG_RESET;
    if (bus_rd) begin
      case (bus_addr)
        tmrc_pkg::ADDR_RUN_STATE: begin
          rdata_next[tmrc_pkg::BIT_CH0] = run_w[tmrc_pkg::UNIT_CH0];
          rdata_next[tmrc_pkg::BIT_CH1] = run_w[tmrc_pkg::UNIT_CH1_LOW];
        end
        tmrc_pkg::ADDR_RUN_STATE_UP: begin
          rdata_next[tmrc_pkg::BIT_CH1] = run_w[tmrc_pkg::UNIT_CH1_UP];
        end
        default: begin
          // Trigger registers and unmapped addresses read zero
          rdata_next = tmrc_pkg::REG_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= tmrc_pkg::REG_RESET;
      run_reg   <= '0;
      init_reg  <= '0;
      rst_reg   <= '0;
    end else begin
      rdata_reg <= rdata_next;
      run_reg   <= run_w;
      init_reg  <= init_w;
      rst_reg   <= rst_w;
    end
  end

  assign bus_rdata     = rdata_reg;
  assign run_enable    = run_reg;
  assign count_init    = init_reg;
  assign count_restart = rst_reg;

  trig_read_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    bus_rd && (bus_addr == tmrc_pkg::ADDR_GO_TRIG ||
               bus_addr == tmrc_pkg::ADDR_GO_TRIG_UP) |=> bus_rdata == 8'h00)
    else $error("go trigger read not zero");
  halt_read_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    bus_rd && (bus_addr == tmrc_pkg::ADDR_HALT_TRIG ||
               bus_addr == tmrc_pkg::ADDR_HALT_TRIG_UP) |=> bus_rdata == 8'h00)
    else $error("halt trigger read not zero");
  status_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    bus_rd && bus_addr == tmrc_pkg::ADDR_RUN_STATE |=>
      bus_rdata == {6'h00, $past(run_w[1]), $past(run_w[0])})
    else $error("status read mismatch");
  upper_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    bus_rd && bus_addr == tmrc_pkg::ADDR_RUN_STATE_UP |=>
      bus_rdata == {6'h00, $past(run_w[2]), 1'b0})
    else $error("upper status read mismatch");
  upper_go_split_a: assert property (@(posedge clk_sys) disable iff (srst)
    bus_wr && bus_addr == tmrc_pkg::ADDR_GO_TRIG_UP && !split_mode
      |-> !go_set[tmrc_pkg::UNIT_CH1_UP])
    else $error("upper go accepted outside split mode");
  start_out_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(run_enable[0]) |-> count_init[0])
    else $error("run enable without counter init");
endmodule // tmrc_run_ctrl

// File: test/tmrc_run_ctrl_bench.sv
`timescale 1ns/1ps
module tmrc_run_ctrl_bench;
  logic                        clk_sys          = 1'b0;
  logic                        srst             = 1'b1;
  logic [tmrc_pkg::ADDR_W-1:0] bus_addr         = 20'h00000;
  logic                        bus_wr           = 1'b0;
  logic                        bus_rd           = 1'b0;
  logic [tmrc_pkg::DATA_W-1:0] bus_wdata        = 8'h00;
  logic [tmrc_pkg::DATA_W-1:0] bus_wmask        = 8'h00;
  logic [2:0]                  ch0_mode         = 3'h0;
  logic [2:0]                  ch1_mode         = 3'h0;
  logic [1:0]                  start_option_bit = 2'h0;
  logic                        split_mode       = 1'b0;
  logic [tmrc_pkg::DATA_W-1:0] bus_rdata;
  logic [tmrc_pkg::UNITS-1:0]  run_enable;
  logic [tmrc_pkg::UNITS-1:0]  count_init;
  logic [tmrc_pkg::UNITS-1:0]  count_restart;
  int                          mismatches       = 0;
  int                          cmp_count        = 0;
  int                          cycles           = 0;

  always #20 clk_sys = ~clk_sys;

  tmrc_run_ctrl DUT (
    .clk_sys          (clk_sys),
    .srst             (srst),
    .bus_addr         (bus_addr),
    .bus_wr           (bus_wr),
    .bus_rd           (bus_rd),
    .bus_wdata        (bus_wdata),
    .bus_wmask        (bus_wmask),
    .ch0_mode         (ch0_mode),
    .ch1_mode         (ch1_mode),
    .start_option_bit (start_option_bit),
    .split_mode       (split_mode),
    .bus_rdata        (bus_rdata),
    .run_enable       (run_enable),
    .count_init       (count_init),
    .count_restart    (count_restart)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d,
                    input logic [7:0] m);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wmask <= m;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd   <= 1'b0;
    // Read data stands only in the cycle after the read edge
    #1;
    chk("bus_rdata", exp, bus_rdata);
  endtask

  // Write a trigger, then look at the outputs two edges later
  task automatic trig(input logic [19:0] a, input logic [7:0] d,
                      input logic [7:0] m, input logic [2:0] run,
                      input logic [2:0] ini, input logic [2:0] rst);
    wr(a, d, m);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("run_enable", {5'h00, run}, {5'h00, run_enable});
    chk("count_init", {5'h00, ini}, {5'h00, count_init});
    chk("count_restart", {5'h00, rst}, {5'h00, count_restart});
    @(posedge clk_sys);
    #1;
    chk("count_init end", 8'h00, {5'h00, count_init});
  endtask

  task automatic read_all_zero;
    rd(tmrc_pkg::ADDR_RUN_STATE, 8'h00);
    rd(tmrc_pkg::ADDR_RUN_STATE_UP, 8'h00);
    rd(tmrc_pkg::ADDR_GO_TRIG, 8'h00);
    rd(tmrc_pkg::ADDR_GO_TRIG_UP, 8'h00);
    rd(tmrc_pkg::ADDR_HALT_TRIG, 8'h00);
    rd(tmrc_pkg::ADDR_HALT_TRIG_UP, 8'h00);
    rd(20'hf01b6, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    read_all_zero();
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h01, 8'hff, 3'h1, 3'h1, 3'h0);
    rd(tmrc_pkg::ADDR_RUN_STATE, 8'h01);
    rd(tmrc_pkg::ADDR_GO_TRIG, 8'h00);
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h00, 8'hff, 3'h1, 3'h0, 3'h0);
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h01, 8'hff, 3'h1, 3'h1, 3'h1);
    trig(tmrc_pkg::ADDR_HALT_TRIG, 8'h01, 8'h01, 3'h0, 3'h0, 3'h0);
    rd(tmrc_pkg::ADDR_HALT_TRIG, 8'h00);
    rd(tmrc_pkg::ADDR_RUN_STATE, 8'h00);
    // One-count mode, restart refused then permitted
    @(posedge clk_sys);
    ch0_mode <= tmrc_pkg::MODE_ONE_COUNT;
    repeat (4) @(posedge clk_sys);
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h01, 8'hff, 3'h1, 3'h1, 3'h0);
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h01, 8'hff, 3'h1, 3'h0, 3'h0);
    @(posedge clk_sys);
    start_option_bit <= 2'h1;
    repeat (4) @(posedge clk_sys);
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h01, 8'hff, 3'h1, 3'h1, 3'h1);
    trig(tmrc_pkg::ADDR_HALT_TRIG, 8'h01, 8'hff, 3'h0, 3'h0, 3'h0);
    // Upper go trigger only acts in split mode
    trig(tmrc_pkg::ADDR_GO_TRIG_UP, 8'h02, 8'hff, 3'h0, 3'h0, 3'h0);
    @(posedge clk_sys);
    split_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    trig(tmrc_pkg::ADDR_GO_TRIG_UP, 8'h02, 8'hff, 3'h4, 3'h4, 3'h0);
    rd(tmrc_pkg::ADDR_RUN_STATE_UP, 8'h02);
    trig(tmrc_pkg::ADDR_GO_TRIG_UP, 8'h02, 8'hff, 3'h4, 3'h4, 3'h4);
    rd(tmrc_pkg::ADDR_RUN_STATE, 8'h00);
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h02, 8'h02, 3'h6, 3'h2, 3'h0);
    rd(tmrc_pkg::ADDR_RUN_STATE, 8'h02);
    trig(tmrc_pkg::ADDR_HALT_TRIG_UP, 8'h02, 8'hff, 3'h2, 3'h0, 3'h0);
    rd(tmrc_pkg::ADDR_RUN_STATE_UP, 8'h00);
    trig(tmrc_pkg::ADDR_HALT_TRIG, 8'h02, 8'hff, 3'h0, 3'h0, 3'h0);
    // Channel 1 in capture and one-count refuses a go while running
    @(posedge clk_sys);
    ch1_mode         <= tmrc_pkg::MODE_CAP_ONE;
    start_option_bit <= 2'h3;
    repeat (4) @(posedge clk_sys);
    // Byte start of both channels, then reset in mid-run
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h03, 8'hff, 3'h3, 3'h3, 3'h0);
    rd(tmrc_pkg::ADDR_RUN_STATE, 8'h03);
    trig(tmrc_pkg::ADDR_GO_TRIG, 8'h03, 8'hff, 3'h3, 3'h1, 3'h1);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("run_enable", 8'h00, {5'h00, run_enable});
    read_all_zero();
    report_and_stop();
  end
endmodule // tmrc_run_ctrl_bench
